// File: hw/dli_pkg.sv
/*
 Shared constants and types of the deinterlacer port block: control word offsets,
 field positions, reset values and the sequencer states.
 Assumes nothing of its surroundings.
*/
package dli_pkg;

   localparam int unsigned CTRL_AW      = 2;
   localparam int unsigned CTRL_DW      = 32;
   localparam logic [1:0]  REG_CONTROL  = 2'h0;
   localparam logic [1:0]  REG_STATUS   = 2'h1;
   localparam logic [1:0]  REG_OVERRIDE = 2'h2;
   localparam logic [1:0]  REG_COEF     = 2'h3;
   localparam int unsigned GO_BIT       = 0;
   localparam int unsigned STATUS_BIT   = 0;
   localparam int unsigned OVERRIDE_BIT = 0;
   localparam int unsigned COEF_W       = 16;
   localparam logic        GO_RST       = 1'b0;
   localparam logic        OVERRIDE_RST = 1'b0;
   localparam logic [15:0] COEF_RST     = 16'h0000;
   localparam logic [15:0] COEF_HALF    = 16'h8000;
   localparam int unsigned BURST_ONE    = 1;

   typedef enum logic [1:0] {
      DLI_IDLE  = 2'b00,
      DLI_WRITE = 2'b01,
      DLI_READ  = 2'b10,
      DLI_OUT   = 2'b11
   } dli_state_t;

endpackage : dli_pkg

// File: hw/dli_rd_if.sv
/*
 Request and answer bundle between the sequencer and one read master.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface dli_rd_if #(
   parameter int unsigned MAW = 32,
   parameter int unsigned MW  = 64
);
   logic           req;
   logic [MAW-1:0] addr;
   logic           done;
   logic [MW-1:0]  data;

   modport core   (output req, output addr, input done, input data);
   modport master (input req, input addr, output done, output data);
endinterface : dli_rd_if

// File: hw/dli_rd_master.sv
/*
 One single-beat read master toward the frame store.
 Assumes an interconnect that returns data no earlier than the cycle after acceptance.
*/
`timescale 1ns/1ps
module dli_rd_master #(
   parameter int unsigned MAW = 32,
   parameter int unsigned MW  = 64,
   parameter int unsigned BCW = 6
) (
   input  wire logic           clock,
   input  wire logic           arst_n,
   input  wire logic           ce,
   dli_rd_if.master            rq,
   output logic [MAW-1:0]      av_address,
   output logic [BCW-1:0]      av_burstcount,
   output logic                av_read,
   input  wire logic [MW-1:0]  av_readdata,
   input  wire logic           av_readdatavalid,
   input  wire logic           av_waitrequest
);
   import dli_pkg::*;

   logic           waiting;
   logic           done;
   logic [MW-1:0]  data;

   assign av_burstcount = BCW'(BURST_ONE);
   assign rq.done       = done;
   assign rq.data       = data;

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         av_read    <= 1'b0;
         av_address <= '0;
         waiting    <= 1'b0;
         done       <= 1'b0;
         data       <= '0;
      end else if (ce) begin
         done <= 1'b0;
         if (rq.req && !av_read && !waiting) begin
            av_read    <= 1'b1;
            av_address <= rq.addr;
         end else if (av_read && !av_waitrequest) begin
            av_read <= 1'b0;
            waiting <= 1'b1;
         end
         if (waiting && av_readdatavalid) begin
            data    <= av_readdata;
            done    <= 1'b1;
            waiting <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   rd_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
      av_read && av_waitrequest && ce |=> av_read && $stable(av_address))
      else $error("read request moved while stalled");
   rd_wait_c: cover property (@(posedge clock) disable iff (!arst_n)
      av_read && av_waitrequest ##1 av_read && !av_waitrequest);

endmodule : dli_rd_master

// File: hw/dli_core.sv
/*
 Deinterlacer port block: stream sink, stream source, blend override control
 port, frame-store write master and read masters, with a word-at-a-time sequencer.
 Assumes all inputs synchronous to clock and reset released on a clock edge.
*/
`timescale 1ns/1ps
module dli_core #(
   parameter int unsigned DW          = 24,
   parameter int unsigned MW          = 64,
   parameter int unsigned MAW         = 32,
   parameter int unsigned BCW         = 6,
   parameter int unsigned NUM_RD      = 2,
   parameter bit          BUFFERED    = 1'b1,
   parameter int unsigned CTRL_PORTS  = 1,
   parameter logic [31:0] BASE_ADDR   = 32'h0000_0000,
   parameter int unsigned FIELD_WORDS = 1024
) (
   input  wire logic                                clock,
   input  wire logic                                arst_n,
   input  wire logic                                ce,
   input  wire logic [DW-1:0]                       din_data,
   input  wire logic                                din_startofpacket,
   input  wire logic                                din_endofpacket,
   input  wire logic                                din_valid,
   output logic                                     din_ready,
   output logic [DW-1:0]                            dout_data,
   output logic                                     dout_startofpacket,
   output logic                                     dout_endofpacket,
   output logic                                     dout_valid,
   input  wire logic                                dout_ready,
   input  wire logic [dli_pkg::CTRL_AW-1:0]         blend_override_ctrl_port_address,
   input  wire logic                                blend_override_ctrl_port_chipselect,
   input  wire logic                                blend_override_ctrl_port_write,
   input  wire logic [dli_pkg::CTRL_DW-1:0]         blend_override_ctrl_port_writedata,
   output logic [dli_pkg::CTRL_DW-1:0]              blend_override_ctrl_port_readdata,
   output logic                                     blend_override_ctrl_port_waitrequest,
   output logic [NUM_RD-1:0][MAW-1:0]               read_master_address,
   output logic [NUM_RD-1:0][BCW-1:0]               read_master_burstcount,
   output logic [NUM_RD-1:0]                        read_master_read,
   input  wire logic [NUM_RD-1:0][MW-1:0]           read_master_readdata,
   input  wire logic [NUM_RD-1:0]                   read_master_readdatavalid,
   input  wire logic [NUM_RD-1:0]                   read_master_waitrequest,
   output logic [MAW-1:0]                           write_master_address,
   output logic [BCW-1:0]                           write_master_burstcount,
   output logic                                     write_master_write,
   output logic [MW-1:0]                            write_master_writedata,
   input  wire logic                                write_master_waitrequest
);
   import dli_pkg::*;

   localparam int unsigned PTR_W   = $clog2(FIELD_WORDS);
   localparam int unsigned BYTE_SH = $clog2(MW / 8);

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter values that the logic cannot serve stop elaboration.
   if (CTRL_PORTS > 1) begin : g_bad_ports
      $error("only one control port may be present");
   end
   if (NUM_RD < 1 || NUM_RD > 2) begin : g_bad_rd
      $error("one or two read masters supported");
   end
   if (DW > MW || MW < 16 || MW > 256 || (MW & (MW - 1)) != 0) begin : g_bad_mw
      $error("bad memory width");
   end
   if (PTR_W + 1 + BYTE_SH > MAW || (FIELD_WORDS & (FIELD_WORDS - 1)) != 0) begin : g_bad_fw
      $error("field does not fit the address");
   end
   if ((BASE_ADDR & ((MW / 8) - 1)) != 0) begin : g_bad_base
      $error("base not word aligned");
   end

   // Word index within the two-bank frame store, scaled to a byte address.
   function automatic logic [MAW-1:0] byte_addr(input logic bank, input logic [PTR_W-1:0] ptr);
      byte_addr = MAW'(BASE_ADDR) + (MAW'({bank, ptr}) << BYTE_SH);
   endfunction : byte_addr

   dli_state_t       state;
   dli_state_t       next_state;
   logic [DW-1:0]    hold_data;
   logic             in_pkt;
   logic             bank;
   logic [PTR_W-1:0] ptr;
   logic             go;
   logic             override;
   logic [15:0]      coef;
   logic             rd_hold;
   logic             go_eff;
   logic             take_in;
   logic             give_out;
   logic             wr_done;
   logic             all_got;
   logic             rd_req;
   logic [DW-1:0]    cur_word;
   logic [DW-1:0]    prev_word;
   logic [DW:0]      mean_sum;
   logic [DW-1:0]    blended;
   logic [DW-1:0]    next_dout;
   logic             cs;
   logic             wr_sel;
   logic [CTRL_DW-1:0] read_mux;
   logic [NUM_RD-1:0]  rd_got;
   logic [NUM_RD-1:0][MW-1:0] rd_word;

   ////////////////////////////////////////////////////////////////////////////////
   // The ready term depends on ce so that a frozen block never completes a handshake on the stream sink.
   assign go_eff     = (CTRL_PORTS == 0) ? 1'b1 : go;
   assign din_ready  = (state == DLI_IDLE) && ce && (go_eff || in_pkt);
   assign dout_valid = (state == DLI_OUT) && ce;
   assign take_in    = din_valid && din_ready;
   assign give_out   = dout_valid && dout_ready;
   assign wr_done    = (state == DLI_WRITE) && !write_master_waitrequest;
   assign rd_req     = wr_done;
   assign all_got    = &rd_got;

   // Gated by ce so that a frozen block never has a write taken twice.
   assign write_master_write      = BUFFERED && (state == DLI_WRITE) && ce;
   assign write_master_burstcount = BCW'(BURST_ONE);

   // Weave takes the stored opposite field, bob the current one, else their mean.
   assign cur_word  = rd_word[0][DW-1:0];
   assign prev_word = rd_word[NUM_RD-1][DW-1:0];
   assign mean_sum  = {1'b0, cur_word} + {1'b0, prev_word};
   assign blended   = (NUM_RD == 1) ? cur_word :
                      override ? ((coef < COEF_HALF) ? prev_word : cur_word) :
                      mean_sum[DW:1];
   assign next_dout = BUFFERED ? blended : din_data;

   always_comb begin
      next_state = state;
      case (state)
         DLI_IDLE:  if (take_in) next_state = BUFFERED ? DLI_WRITE : DLI_OUT;
         DLI_WRITE: if (wr_done) next_state = DLI_READ;
         DLI_READ:  if (all_got) next_state = DLI_OUT;
         DLI_OUT:   if (give_out) next_state = DLI_IDLE;
         default:   next_state = DLI_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state              <= DLI_IDLE;
         hold_data          <= '0;
         dout_data          <= '0;
         dout_startofpacket <= 1'b0;
         dout_endofpacket   <= 1'b0;
         in_pkt             <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         if (take_in) begin
            hold_data          <= din_data;
            dout_startofpacket <= din_startofpacket;
            dout_endofpacket   <= din_endofpacket;
            in_pkt             <= !din_endofpacket;
         end
         if ((take_in && !BUFFERED) || (state == DLI_READ && all_got))
            dout_data <= next_dout;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bank                   <= 1'b0;
         ptr                    <= '0;
         write_master_address   <= '0;
         write_master_writedata <= '0;
      end else if (ce) begin
         if (take_in) begin
            write_master_address   <= byte_addr(bank, ptr);
            write_master_writedata <= MW'(din_data);
         end
         if (give_out && dout_endofpacket) begin
            ptr  <= '0;
            bank <= !bank;
         end else if (give_out) begin
            ptr <= ptr + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   generate
      for (genvar g = 0; g < NUM_RD; g++) begin : g_rd
         dli_rd_if #(.MAW(MAW), .MW(MW)) rq ();
         assign rq.req  = rd_req;
         assign rq.addr = byte_addr((g == 0) ? bank : !bank, ptr);
         dli_rd_master #(.MAW(MAW), .MW(MW), .BCW(BCW)) u_rd (
            .clock            (clock),
            .arst_n           (arst_n),
            .ce               (ce),
            .rq               (rq),
            .av_address       (read_master_address[g]),
            .av_burstcount    (read_master_burstcount[g]),
            .av_read          (read_master_read[g]),
            .av_readdata      (read_master_readdata[g]),
            .av_readdatavalid (read_master_readdatavalid[g]),
            .av_waitrequest   (read_master_waitrequest[g])
         );
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               rd_got[g]  <= 1'b0;
               rd_word[g] <= '0;
            end else if (ce) begin
               if (rq.done) begin
                  rd_got[g]  <= 1'b1;
                  rd_word[g] <= rq.data;
               end else if (state != DLI_READ) begin
                  rd_got[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Reads always pay one wait cycle, which keeps the read data a flip-flop.
   assign cs       = blend_override_ctrl_port_chipselect && (CTRL_PORTS == 1);
   assign wr_sel   = cs && blend_override_ctrl_port_write;
   assign read_mux = (blend_override_ctrl_port_address == REG_CONTROL) ?
                        CTRL_DW'(go) << GO_BIT :
                     (blend_override_ctrl_port_address == REG_STATUS) ?
                        CTRL_DW'(in_pkt || state != DLI_IDLE) << STATUS_BIT :
                        '0;
   assign blend_override_ctrl_port_waitrequest = cs && !blend_override_ctrl_port_write
                                                 && !rd_hold;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         go       <= GO_RST;
         override <= OVERRIDE_RST;
         coef     <= COEF_RST;
         rd_hold  <= 1'b0;
         blend_override_ctrl_port_readdata <= '0;
      end else if (ce) begin
         rd_hold <= cs && !blend_override_ctrl_port_write && !rd_hold;
         if (cs) blend_override_ctrl_port_readdata <= read_mux;
         if (wr_sel) begin
            case (blend_override_ctrl_port_address)
               REG_CONTROL:  go       <= blend_override_ctrl_port_writedata[GO_BIT];
               REG_OVERRIDE: override <= blend_override_ctrl_port_writedata[OVERRIDE_BIT];
               REG_COEF:     coef     <= blend_override_ctrl_port_writedata[COEF_W-1:0];
               default:      ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   ready_idle_a: assert property (din_ready |-> state == DLI_IDLE)
      else $error("input ready outside idle");
   stop_gate_a: assert property (!go_eff && !in_pkt |-> !din_ready)
      else $error("new packet taken while stopped");
   out_hold_a: assert property (dout_valid && !dout_ready && ce |=> dout_valid
      && $stable(dout_data) && $stable(dout_endofpacket) && $stable(dout_startofpacket))
      else $error("output word changed while stalled");
   out_valid_a: assert property (state == DLI_OUT && ce |-> dout_valid)
      else $error("word presented without valid");
   eop_wrap_a: assert property (give_out && dout_endofpacket |=> ptr == '0)
      else $error("pointer not reset after end of packet");
   wr_hold_a: assert property (write_master_write && write_master_waitrequest && ce
      |=> write_master_write && $stable(write_master_address)
      && $stable(write_master_writedata))
      else $error("write request moved while stalled");
   byte_addr_a: assert property (write_master_write |->
      write_master_address[BYTE_SH-1:0] == '0 && write_master_burstcount == BCW'(BURST_ONE))
      else $error("write address not a word-aligned byte address");
   cs_ignore_a: assert property (!blend_override_ctrl_port_chipselect && ce
      |=> $stable(go) && $stable(coef) && $stable(override))
      else $error("register changed without chip select");
   coef_write_a: assert property (wr_sel && blend_override_ctrl_port_address == REG_COEF && ce
      |=> coef == $past(blend_override_ctrl_port_writedata[COEF_W-1:0]))
      else $error("coefficient write lost");
   read_wait_a: assert property (cs && !blend_override_ctrl_port_write && !rd_hold && ce
      |-> blend_override_ctrl_port_waitrequest ##1 !blend_override_ctrl_port_waitrequest)
      else $error("read wait not exactly one cycle");

   pkt_out_c: cover property (give_out && dout_endofpacket);
   wr_stall_c: cover property (write_master_write && write_master_waitrequest ##1 wr_done);
   reg_read_c: cover property (blend_override_ctrl_port_waitrequest ##1 cs && rd_hold);
   override_c: cover property (override && state == DLI_READ && all_got);

endmodule : dli_core

// File: verification/dli_mem_model.sv
/*
 Frame-store model that answers the write master and the read masters.
 Assumes the main clock and reset, and byte addresses below 32'h100.
*/
`timescale 1ns/1ps
module dli_mem_model #(
   parameter int unsigned NUM_RD = 2
) (
   input  wire logic                    clock,
   input  wire logic                    arst_n,
   input  wire logic                    slow,
   input  wire logic [NUM_RD-1:0][31:0] read_master_address,
   input  wire logic [NUM_RD-1:0]       read_master_read,
   output logic [NUM_RD-1:0][63:0]      read_master_readdata,
   output logic [NUM_RD-1:0]            read_master_readdatavalid,
   output logic [NUM_RD-1:0]            read_master_waitrequest,
   input  wire logic [31:0]             write_master_address,
   input  wire logic                    write_master_write,
   input  wire logic [63:0]             write_master_writedata,
   output logic                         write_master_waitrequest
);
   logic [63:0]            mem [32];
   logic [NUM_RD-1:0][1:0] rcnt;
   logic [1:0]             wcnt;
   wire                    w_take = write_master_write && !write_master_waitrequest;
   wire [NUM_RD-1:0]       r_take = read_master_read & ~read_master_waitrequest;
   initial for (int i = 0; i < 32; i++) mem[i] = '0;
   ////////////////////////////////////////////////////////////////////////////////
   // Slow mode holds every request off for two cycles, so a master that moves on
   // early loses its word.
   always_comb begin
      write_master_waitrequest = slow && wcnt != 2'h2;
      for (int n = 0; n < NUM_RD; n++) read_master_waitrequest[n] = slow && rcnt[n] != 2'h2;
   end
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wcnt <= '0;
         rcnt <= '0;
         read_master_readdatavalid <= '0;
         read_master_readdata <= '1;
      end else begin
         if (write_master_write) wcnt <= w_take ? 2'h0 : wcnt + 2'h1;
         if (w_take) mem[write_master_address[7:3]] <= write_master_writedata;
         for (int n = 0; n < NUM_RD; n++) begin
            if (read_master_read[n]) rcnt[n] <= r_take[n] ? 2'h0 : rcnt[n] + 2'h1;
            read_master_readdatavalid[n] <= r_take[n];
            // Between answers the bus toggles, so a stale word never looks valid.
            read_master_readdata[n] <= r_take[n] ? mem[read_master_address[n][7:3]]
                                                 : ~read_master_readdata[n];
         end
      end
   end
endmodule : dli_mem_model

// File: verification/dli_core_tb_top.sv
/*
 Self-checking bench of the deinterlacer port block with a frame-store model.
 Assumes FIELD_WORDS of 16 and a frame base at address zero.
*/
`timescale 1ns/1ps
module dli_core_tb_top;
   import dli_pkg::*;
   localparam logic [31:0] BASE = 32'h0000_0000;
   logic                clock = 1'b0;
   logic                arst_n = 1'b0;
   logic                ce = 1'b1;
   logic                slow = 1'b0;
   logic [23:0]         din_data = '0;
   logic [23:0]         dout_data;
   logic                din_startofpacket = 1'b0;
   logic                din_endofpacket = 1'b0;
   logic                din_valid = 1'b0;
   logic                din_ready, dout_startofpacket, dout_endofpacket, dout_valid;
   logic                dout_ready = 1'b0;
   logic [CTRL_AW-1:0]  blend_override_ctrl_port_address = '0;
   logic                blend_override_ctrl_port_chipselect = 1'b0;
   logic                blend_override_ctrl_port_write = 1'b0;
   logic [CTRL_DW-1:0]  blend_override_ctrl_port_writedata = '0;
   logic [CTRL_DW-1:0]  blend_override_ctrl_port_readdata;
   logic                blend_override_ctrl_port_waitrequest;
   logic [1:0][31:0]    read_master_address;
   logic [1:0][5:0]     read_master_burstcount;
   logic [1:0]          read_master_read, read_master_readdatavalid, read_master_waitrequest;
   logic [1:0][63:0]    read_master_readdata;
   logic [31:0]         write_master_address;
   logic [5:0]          write_master_burstcount;
   logic                write_master_write, write_master_waitrequest;
   logic [63:0]         write_master_writedata;
   logic                bank = 1'b0;
   logic [3:0]          ptr = 4'h0;
   int                  n_mismatch = 0;
   int                  total_checks = 0;
   dli_core #(.FIELD_WORDS(16), .BASE_ADDR(BASE)) u_dli_core (.*);
   dli_mem_model #(.NUM_RD(2)) u_dli_mem_model (.*);
   initial forever #2 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick();
      @(posedge clock);
      #1;
   endtask : tick
   // An expired wait is a hang, so the run ends at once.
   task automatic guard(input logic ok);
      if (ok !== 1'b1) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask : guard
   task automatic ctrl(input logic cs, wr, input logic [1:0] a, input logic [31:0] d, exp);
      blend_override_ctrl_port_chipselect = cs;
      blend_override_ctrl_port_write = wr;
      blend_override_ctrl_port_address = a;
      blend_override_ctrl_port_writedata = d;
      #1;
      for (int i = 0; i < 8 && blend_override_ctrl_port_waitrequest !== 1'b0; i++) tick();
      guard(!blend_override_ctrl_port_waitrequest);
      if (cs && !wr) chk(blend_override_ctrl_port_readdata, exp);
      tick();
      blend_override_ctrl_port_chipselect = 1'b0;
      blend_override_ctrl_port_write = 1'b0;
      tick();
   endtask : ctrl
   task automatic xfer(input logic [23:0] d, exp, input logic s, e, input int hold);
      din_data = d;
      din_startofpacket = s;
      din_endofpacket = e;
      din_valid = 1'b1;
      #1;
      for (int i = 0; i < 60 && din_ready !== 1'b1; i++) tick();
      guard(din_ready);
      tick();
      din_valid = 1'b0;
      din_data = ~d;
      for (int i = 0; i < 60 && write_master_write !== 1'b1; i++) tick();
      guard(write_master_write);
      chk(write_master_address, BASE + {bank, ptr, 3'h0});
      chk(write_master_writedata, {40'h0, d});
      chk(write_master_burstcount, 6'h01);
      for (int i = 0; i < 60 && read_master_read !== 2'b11; i++) tick();
      guard(&read_master_read);
      chk(read_master_address, {BASE + {~bank, ptr, 3'h0}, BASE + {bank, ptr, 3'h0}});
      chk(read_master_burstcount, {6'h01, 6'h01});
      for (int i = 0; i < 60 && dout_valid !== 1'b1; i++) tick();
      guard(dout_valid);
      repeat (hold) begin
         tick();
         chk({dout_valid, dout_data}, {1'b1, exp});
      end
      dout_ready = 1'b1;
      chk({dout_startofpacket, dout_endofpacket, dout_data}, {s, e, exp});
      tick();
      dout_ready = 1'b0;
      #1 chk(dout_valid, 1'b0);
      ptr = e ? 4'h0 : ptr + 4'h1;
      if (e) bank = ~bank;
   endtask : xfer
   function automatic logic [23:0] avg(input logic [23:0] a, b);
      return 24'((25'(a) + 25'(b)) >> 1);
   endfunction : avg
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clock);
      #1 arst_n = 1'b1;
      din_valid = 1'b1;
      repeat (3) tick();
      chk(din_ready, 1'b0);
      din_valid = 1'b0;
      ctrl(1'b1, 1'b1, REG_CONTROL, 32'h1, 32'h0);
      ctrl(1'b0, 1'b1, REG_CONTROL, 32'h0, 32'h0);
      ctrl(1'b1, 1'b0, REG_CONTROL, 32'h0, 32'h1);
      ctrl(1'b1, 1'b0, REG_STATUS, 32'h0, 32'h0);
      ctrl(1'b1, 1'b1, REG_OVERRIDE, 32'h1, 32'h0);
      ctrl(1'b1, 1'b0, REG_OVERRIDE, 32'h0, 32'h0);
      ctrl(1'b1, 1'b1, REG_COEF, {16'h0, COEF_HALF}, 32'h0);
      ce = 1'b0;
      din_valid = 1'b1;
      tick();
      chk(din_ready, 1'b0);
      din_valid = 1'b0;
      ce = 1'b1;
      xfer(24'h123456, 24'h123456, 1'b1, 1'b0, 0);
      xfer(24'hfedcba, 24'hfedcba, 1'b0, 1'b1, 3);
      slow = 1'b1;
      ctrl(1'b1, 1'b1, REG_COEF, 32'h0, 32'h0);
      xfer(24'h0f0f0f, 24'h123456, 1'b1, 1'b0, 2);
      xfer(24'h808081, 24'hfedcba, 1'b0, 1'b1, 0);
      slow = 1'b0;
      ctrl(1'b1, 1'b1, REG_OVERRIDE, 32'h0, 32'h0);
      xfer(24'h111111, avg(24'h111111, 24'h0f0f0f), 1'b1, 1'b0, 0);
      xfer(24'hf0f0f1, avg(24'hf0f0f1, 24'h808081), 1'b0, 1'b1, 0);
      report_and_stop();
   end
endmodule : dli_core_tb_top
